// ### apbl_host.sv
// Host controller driving the pseudo-static RAM byte-lane port through its pins
// Function
// - All write strobes asserted before start; first to release ends write.
// - Host times data setup and hold to the strobe that ends the write.
// - Host must not drive data while the device drives its pins.
// - Fastest reads are chip-enable controlled with address stable beforehand.
// - Standard reads need address settled within a fixed delay of cycle start.
// - Host keeps write enable high throughout every read cycle.
`timescale 1ns/10ps
module apbl_host #(
   parameter int ADDR_W = apbl_pkg::ADDR_W,
   parameter int DATA_W = apbl_pkg::DATA_W
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   // User request side
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [1:0]        req_lanes,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   // Device pins
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   chip_sel_n,
   output logic                   chip_sel_high_active,
   output logic                   write_en_n,
   output logic                   out_en_n,
   output logic                   upper_lane_en_n,
   output logic                   lower_lane_en_n,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0]      mem_data_out,
   output logic                   mem_data_oe
);
   apbl_pkg::apbl_state_type   state_ff;
   apbl_pkg::apbl_state_type   nxt_state;
   logic [apbl_pkg::CNT_W-1:0] cnt_ff;
   logic [apbl_pkg::CNT_W-1:0] nxt_cnt;
   logic [DATA_W-1:0]          din_meta_ff;
   logic [DATA_W-1:0]          din_sync_ff;
   logic [1:0]                 lanes_ff;
   logic                       cnt_done;

   assign cnt_done = (cnt_ff == apbl_pkg::CNT_ZERO);

   // Two-stage synchroniser on returning data pins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         din_meta_ff <= '0;
         din_sync_ff <= '0;
      end else begin
         din_meta_ff <= mem_data_in;
         din_sync_ff <= din_meta_ff;
      end
   end

   // Sequencer: next state and cycle counter
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 4'h1;
      case (state_ff)
         apbl_pkg::APBL_IDLE: begin
            if (req_valid && req_lanes != apbl_pkg::LANE_NONE) begin
               nxt_state = req_write ? apbl_pkg::APBL_WSEL : apbl_pkg::APBL_RSEL;
            end
         end
         apbl_pkg::APBL_RSEL: begin
            nxt_state = apbl_pkg::APBL_RDATA;
            nxt_cnt   = apbl_pkg::READ_LOAD;
         end
         apbl_pkg::APBL_RDATA: begin
            if (cnt_done) begin
               nxt_state = apbl_pkg::APBL_TURN;
               nxt_cnt   = apbl_pkg::TURN_LOAD;
            end
         end
         apbl_pkg::APBL_WSEL: begin
            nxt_state = apbl_pkg::APBL_WPULS;
            nxt_cnt   = apbl_pkg::WPULSE_LOAD;
         end
         apbl_pkg::APBL_WPULS: begin
            if (cnt_done) begin
               nxt_state = apbl_pkg::APBL_WEND;
            end
         end
         apbl_pkg::APBL_WEND: begin
            nxt_state = apbl_pkg::APBL_IDLE;
         end
         apbl_pkg::APBL_TURN: begin
            if (cnt_done) begin
               nxt_state = apbl_pkg::APBL_IDLE;
            end
         end
         default: nxt_state = apbl_pkg::APBL_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= apbl_pkg::APBL_IDLE;
         cnt_ff   <= apbl_pkg::CNT_ZERO;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // Latch request at acceptance
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mem_addr     <= '0;
         mem_data_out <= '0;
         lanes_ff     <= apbl_pkg::LANE_NONE;
      end else if (state_ff == apbl_pkg::APBL_IDLE && nxt_state != apbl_pkg::APBL_IDLE) begin
         mem_addr     <= req_addr;
         mem_data_out <= req_wdata;
         lanes_ff     <= req_lanes;
      end
   end

   // Chip enables: asserted from the cycle after address is placed, held through write end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         chip_sel_n           <= apbl_pkg::STROBE_OFF_N;
         chip_sel_high_active <= apbl_pkg::STROBE_OFF;
      end else begin
         chip_sel_n <= !(nxt_state == apbl_pkg::APBL_RDATA ||
                         nxt_state == apbl_pkg::APBL_WPULS ||
                         nxt_state == apbl_pkg::APBL_WEND);
         chip_sel_high_active <= (nxt_state == apbl_pkg::APBL_RDATA ||
                                  nxt_state == apbl_pkg::APBL_WPULS ||
                                  nxt_state == apbl_pkg::APBL_WEND);
      end
   end

   // Lane enables follow the latched lane choice during an access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         upper_lane_en_n <= apbl_pkg::STROBE_OFF_N;
         lower_lane_en_n <= apbl_pkg::STROBE_OFF_N;
      end else if (nxt_state == apbl_pkg::APBL_RDATA ||
                   nxt_state == apbl_pkg::APBL_WPULS ||
                   nxt_state == apbl_pkg::APBL_WEND) begin
         upper_lane_en_n <= !lanes_ff[1];
         lower_lane_en_n <= !lanes_ff[0];
      end else begin
         upper_lane_en_n <= apbl_pkg::STROBE_OFF_N;
         lower_lane_en_n <= apbl_pkg::STROBE_OFF_N;
      end
   end

   // Write enable pulses inside the chip-enable window
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         write_en_n <= apbl_pkg::STROBE_OFF_N;
      end else begin
         // write strobe nested in overlap, released first
         // write enable high in reads
         // Released while the enables still stand, so it alone ends the write
         write_en_n <= !(nxt_state == apbl_pkg::APBL_WPULS && state_ff == apbl_pkg::APBL_WPULS
                         && !cnt_done);
      end
   end

   // Output enable only in reads
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         out_en_n <= apbl_pkg::STROBE_OFF_N;
      end else begin
         // output enable held high through writes
         out_en_n <= !(nxt_state == apbl_pkg::APBL_RDATA);
      end
   end

   // Host data drive: write accesses plus one cycle after the chip enables drop, never when device may drive
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mem_data_oe <= 1'b0;
      end else begin
         // data held past write enable release
         mem_data_oe <= (nxt_state == apbl_pkg::APBL_WPULS ||
                         nxt_state == apbl_pkg::APBL_WEND ||
                         state_ff == apbl_pkg::APBL_WEND);
      end
   end

   // Handshake and read capture; unused lanes read as zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         req_ready <= (nxt_state == apbl_pkg::APBL_IDLE);
         rsp_valid <= 1'b0;
         if (state_ff == apbl_pkg::APBL_RDATA && cnt_done) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= {lanes_ff[1] ? din_sync_ff[DATA_W-1:apbl_pkg::LANE_W] : 8'h00,
                          lanes_ff[0] ? din_sync_ff[apbl_pkg::LANE_W-1:0] : 8'h00};
         end
      end
   end
endmodule

// ### apbl_pkg.sv
// Package of pin encodings, lane maps and strobe timing for the pseudo-static RAM host port
package apbl_pkg;
   // Clock rate
   localparam int CLK_PERIOD_NS = 40;
   // Bus widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   // Device timing in ns, as printed
   localparam int READ_CYCLE_NS      = 70;
   localparam int CHIP_SEL_ACCESS_NS = 70;
   localparam int WRITE_CYCLE_NS     = 70;
   localparam int WRITE_PULSE_NS     = 55;
   localparam int DATA_SETUP_NS      = 25;
   localparam int OUT_HIGHZ_NS       = 25;
   localparam int ADDRESS_SKEW_NS    = 10;
   // Cycle counts: least times round up, plus one for read, at least one cycle
   localparam int READ_CYC   = (CHIP_SEL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int WPULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC   = (OUT_HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W      = 4;
   // Counter loads
   localparam logic [3:0] READ_LOAD   = 4'(READ_CYC - 1);
   localparam logic [3:0] WPULSE_LOAD = 4'(WPULSE_CYC);
   localparam logic [3:0] TURN_LOAD   = 4'(TURN_CYC);
   localparam logic [3:0] CNT_ZERO    = 4'h0;
   // Byte-lane select codes on the user side: bit 1 upper, bit 0 lower
   localparam logic [1:0] LANE_NONE  = 2'h0;
   localparam logic [1:0] LANE_LOWER = 2'h1;
   localparam logic [1:0] LANE_UPPER = 2'h2;
   localparam logic [1:0] LANE_BOTH  = 2'h3;
   // Pin idle levels
   localparam logic STROBE_OFF_N = 1'b1;
   localparam logic STROBE_OFF   = 1'b0;
   // Controller states, gray from idle into each access, not on the return to idle
   typedef enum logic [2:0] {
      APBL_IDLE  = 3'h0,
      APBL_RSEL  = 3'h1,
      APBL_RDATA = 3'h3,
      APBL_WSEL  = 3'h2,
      APBL_WPULS = 3'h6,
      APBL_WEND  = 3'h7,
      APBL_TURN  = 3'h5
   } apbl_state_type;
endpackage

// ### apbl_host_sva.sv
// Checker of the host port pin protocol
`timescale 1ns/10ps
module apbl_host_sva #(
   parameter int ADDR_W = apbl_pkg::ADDR_W,
   parameter int DATA_W = apbl_pkg::DATA_W
) (
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic              req_valid,
   input wire logic              req_write,
   input wire logic              req_ready,
   input wire logic [1:0]        req_lanes,
   input wire logic              rsp_valid,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              chip_sel_n,
   input wire logic              chip_sel_high_active,
   input wire logic              write_en_n,
   input wire logic              out_en_n,
   input wire logic              upper_lane_en_n,
   input wire logic              lower_lane_en_n,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic              mem_data_oe
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // Accepted request and the write strobe pulse
   sequence take;
      req_valid && req_ready && req_lanes != 2'h0;
   endsequence
   sequence wr_pulse;
      !write_en_n [*2] ##1 write_en_n;
   endsequence
   we_qual_a: assert property (!write_en_n |-> out_en_n && !chip_sel_n
      && chip_sel_high_active && !(upper_lane_en_n && lower_lane_en_n))
      else $error("write strobe without enables");
   we_first_a: assert property ($rose(write_en_n) |-> !chip_sel_n ##1 chip_sel_n)
      else $error("write not ended by write strobe");
   data_hold_a: assert property ($rose(write_en_n) |-> mem_data_oe
      ##1 (mem_data_oe && $stable(mem_data_out))) else $error("write data not held");
   no_drive_a: assert property (!out_en_n |-> !mem_data_oe && write_en_n)
      else $error("host drives during read");
   addr_hold_a: assert property ($fell(chip_sel_n) |-> $stable(mem_addr))
      else $error("address moves at select");
   lane_map_a: assert property (take |-> ##2
      {upper_lane_en_n, lower_lane_en_n} == ~$past(req_lanes, 2)) else $error("lane map");
   rd_lat_a: assert property (take ##0 !req_write |-> ##5 rsp_valid)
      else $error("read response late");
   wr_seq_a: assert property (take ##0 req_write |-> ##2 mem_data_oe ##1 wr_pulse)
      else $error("write sequence wrong");
endmodule
bind apbl_host apbl_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_apbl_host_sva (.*);

// ### apbl_ram_model.sv
// Behavioural model of the pseudo-static RAM byte-lane port
`timescale 1ns/10ps
module apbl_ram_model (
   input  wire logic [19:0] mem_addr,
   input  wire logic        chip_sel_n,
   input  wire logic        chip_sel_high_active,
   input  wire logic        write_en_n,
   input  wire logic        out_en_n,
   input  wire logic        upper_lane_en_n,
   input  wire logic        lower_lane_en_n,
   input  wire logic [15:0] mem_data_in,
   output logic      [15:0] dev_q
);
   logic [15:0] mem [16];
   logic [15:0] cur;
   logic        sel;
   logic        wr;
   logic        rd;
   logic [1:0]  lat_n;
   // selected with both enables and a lane
   assign sel = !chip_sel_n && chip_sel_high_active && !(upper_lane_en_n && lower_lane_en_n);
   assign cur = mem[mem_addr[3:0]];
   assign wr = sel && !write_en_n;
   // read only with write strobe high
   assign rd = sel && write_en_n && !out_en_n;
   // floating lanes show the inverse word
   always_comb begin
      dev_q = ~cur;
      if (rd && !lower_lane_en_n) dev_q[7:0] = cur[7:0];
      if (rd && !upper_lane_en_n) dev_q[15:8] = cur[15:8];
   end
   // lanes held while the overlap lasts
   always_latch if (wr) lat_n = {upper_lane_en_n, lower_lane_en_n};
   // store at the edge ending the write
   always @(negedge wr) begin
      if (!lat_n[0]) mem[mem_addr[3:0]][7:0] = mem_data_in[7:0];
      if (!lat_n[1]) mem[mem_addr[3:0]][15:8] = mem_data_in[15:8];
   end
   // Power-up contents
   initial foreach (mem[i]) mem[i] = 16'h0000;
endmodule

// ### tb_top.sv
// Testbench of the host port against the RAM model
`timescale 1ns/10ps
module tb_top;
   logic        clock, nrst, req_valid, req_write, req_ready, rsp_valid, mem_data_oe;
   logic        chip_sel_n, chip_sel_high_active, write_en_n, out_en_n;
   logic        upper_lane_en_n, lower_lane_en_n;
   logic [1:0]  req_lanes;
   logic [19:0] req_addr, mem_addr;
   logic [15:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out, dev_q;
   int          n_mismatch = 0;
   int          checks_done = 0;
   // Shared data wire: the host drives it only when enabled
   assign mem_data_in = mem_data_oe ? mem_data_out : dev_q;
   apbl_host u_apbl_host (.*);
   apbl_ram_model u_apbl_ram_model (.*);
   // Clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Compare and count
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Bounded wait for ready or a response
   task automatic wait_hi(input bit rsp);
      for (int i = 0; (rsp ? rsp_valid : req_ready) !== 1'b1; i++) begin
         if (i == 20) begin
            n_mismatch++;
            stop_test();
         end
         @(posedge clock);
         #1;
      end
   endtask
   // One request, held for the taking edge
   task automatic send(input logic wr, input logic [19:0] a, input logic [15:0] d,
                       input logic [1:0] ln);
      wait_hi(1'b0);
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_lanes = ln;
      req_valid = 1'b1;
      @(posedge clock);
      #1;
      req_valid = 1'b0;
   endtask
   // Read and compare the response
   task automatic rd(input logic [19:0] a, input logic [1:0] ln, input logic [15:0] exp);
      send(1'b0, a, 16'h0000, ln);
      wait_hi(1'b1);
      chk("read data", rsp_rdata, exp);
   endtask
   // Word write, then word and single-lane reads
   task automatic t_word();
      send(1'b1, 20'h00005, 16'ha5c3, 2'h3);
      rd(20'h00005, 2'h3, 16'ha5c3);
      rd(20'h00005, 2'h1, 16'h00c3);
      rd(20'h00005, 2'h2, 16'ha500);
   endtask
   // Back-to-back single-lane writes keep the other byte
   task automatic t_byte();
      send(1'b1, 20'h00005, 16'h1234, 2'h1);
      send(1'b1, 20'h00005, 16'h5678, 2'h2);
      rd(20'h00005, 2'h3, 16'h5634);
   endtask
   // A request with no lanes leaves the device deselected
   task automatic t_none();
      send(1'b1, 20'h00005, 16'hffff, 2'h0);
      repeat (3) begin
         @(posedge clock);
         #1;
         chk("chip select", 16'(chip_sel_n), 16'h0001);
         chk("chip select high", 16'(chip_sel_high_active), 16'h0000);
         chk("ready", 16'(req_ready), 16'h0001);
      end
      rd(20'h00005, 2'h3, 16'h5634);
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 20'h00000;
      req_wdata = 16'h0000;
      req_lanes = 2'h0;
      repeat (20) @(posedge clock);
      #1;
      nrst = 1'b1;
      t_word();
      t_byte();
      t_none();
      stop_test();
   end
endmodule
